// File: hw/sel_pkg.sv
package sel_pkg;
  localparam int          AW          = 6;
  localparam int          DW          = 16;
  localparam logic [2:0]  STRAP_DFLT  = 3'h7;
  localparam logic [5:0]  SA_BASE     = 6'h20;
  localparam logic [1:0]  SA_LAST     = 2'h2;
  localparam logic [15:0] CFG_DFLT    = 16'h0000;
  localparam logic [15:0] BASE_DFLT   = 16'h0300;
  localparam int          SK_HALF     = 63;   // Slow serial clock, about 2 MHz
  localparam int          READY_MAX   = 4000; // Cycles of ready polling bound
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_EWEN     = 2'h0;
  localparam logic [5:0]  EWEN_ADDR   = 6'h30;
  localparam int          CMD_BITS    = 9;    // Start bit, opcode, address
  typedef struct packed {
    logic select;
    logic reload;
    logic store;
  } sel_ctl_t;
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sel_ser_t;
endpackage

// File: hw/sel_wire.sv
`timescale 1ns/100ps
// One three-wire word access: optional data phase and ready wait
module sel_wire
  import sel_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic [1:0]    op_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          do_i,
  output sel_ser_t           ser_o,
  output logic [DW-1:0]      rdata_o,
  output logic               done_o
);
  typedef enum logic [2:0] {W_IDLE, W_CMD, W_DATA, W_GAP, W_BUSY, W_END}
    sel_wst_t;
  sel_wst_t         st_q;
  logic [7:0]       div_q;
  logic [4:0]       cnt_q;
  logic [24:0]      sh_q;
  logic [DW-1:0]    rd_q;
  logic [12:0]      wait_q;
  logic             do_s1_q, do_s2_q;
  logic             tick;

  assign tick = (div_q == 8'(SK_HALF));

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      do_s1_q <= 1'b0;
      do_s2_q <= 1'b0;
    end
    else
    begin
      do_s1_q <= do_i;
      do_s2_q <= do_s1_q;
    end

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      div_q <= 8'h00;
    else if (st_q == W_IDLE || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      st_q   <= W_IDLE;
      ser_o  <= '0;
      cnt_q  <= 5'h00;
      sh_q   <= '0;
      rd_q   <= '0;
      wait_q <= 13'h0000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (st_q)
        W_IDLE:
          if (start_i)
          begin
            // Start bit goes out with select, well before the first rise
            sh_q   <= {op_i, addr_i, wdata_i, 1'b0};
            cnt_q  <= 5'(CMD_BITS);
            ser_o  <= '{cs: 1'b1, sk: 1'b0, di: 1'b1};
            st_q   <= W_CMD;
          end
        W_CMD, W_DATA:
          if (tick)
          begin
            ser_o.sk <= ~ser_o.sk;
            if (ser_o.sk)
            begin
              // Data moves on the fall so it is settled when the part samples
              ser_o.di <= sh_q[24];
              sh_q     <= {sh_q[23:0], 1'b0};
              if (st_q == W_DATA && op_i == OP_READ)
                rd_q <= {rd_q[DW-2:0], do_s2_q};
              if (cnt_q == 5'h01)
              begin
                if (st_q == W_CMD && op_i != OP_EWEN)
                begin
                  cnt_q <= 5'(DW);
                  st_q  <= W_DATA;
                end
                else
                  st_q <= W_GAP;
              end
              else
                cnt_q <= cnt_q - 5'h01;
            end
          end
        W_GAP:
          if (tick)
          begin
            ser_o.cs <= 1'b0;
            ser_o.di <= 1'b0;
            wait_q   <= 13'h0000;
            st_q     <= (op_i == OP_WRITE) ? W_BUSY : W_END;
          end
        W_BUSY:
        begin
          // Chip select raised again so the part reports busy on its output
          ser_o.cs <= 1'b1;
          wait_q   <= wait_q + 13'h0001;
          // The released line still shows a stale level through the
          // synchroniser, so ready is only trusted after half a clock
          if ((wait_q > 13'(SK_HALF) && do_s2_q)
              || wait_q == 13'(READY_MAX))
            st_q <= W_END;
        end
        default:
        begin
          ser_o  <= '0;
          done_o <= 1'b1;
          st_q   <= W_IDLE;
        end
      endcase
    end

  assign rdata_o = rd_q;
endmodule // sel_wire

// File: hw/sel_loader.sv
`timescale 1ns/100ps
module sel_loader
  import sel_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [2:0]    board_select_straps_i,
  input  wire logic          eeprom_present_pin_i,
  input  wire logic          eeprom_do_i,
  output sel_ser_t           eeprom_o,
  input  wire logic          ctl_wr_i,
  input  sel_ctl_t           ctl_wdata_i,
  output sel_ctl_t           control_register_o,
  input  wire logic          cfg_wr_i,
  input  wire logic          base_wr_i,
  input  wire logic          gp_wr_i,
  input  wire logic          ptr_wr_i,
  input  wire logic [2:0]    sa_wr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0]      cfg_o,
  output logic [DW-1:0]      base_o,
  output logic [DW-1:0]      gp_o,
  output logic [AW-1:0]      ptr_o,
  output logic [3*DW-1:0]    station_address_word_o,
  output logic               access_blocked_o
);
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_EWEN, S_XFER, S_NEXT}
    sel_st_t;
  sel_st_t       st_q;
  sel_ctl_t      ctl_q;
  logic [2:0]    str_s1_q, str_s2_q, strap_q;
  logic          en_s1_q, en_s2_q;
  logic [1:0]    step_q;    // 0 cfg, 1 base while is_sa_q is low; station words use sa_q
  logic [1:0]    sa_q;
  logic          is_sa_q;
  logic          wr_op_q;
  logic          start_q;
  logic [1:0]    op_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wd_q;
  logic [DW-1:0] rdata;
  logic          done;
  logic          busy;

  function automatic logic [AW-1:0] slot_addr(input logic [2:0] s,
                                               input logic b);
    slot_addr = {1'b0, s, 1'b0, b};
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      str_s1_q <= 3'h0;
      str_s2_q <= 3'h0;
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
    end
    else
    begin
      str_s1_q <= board_select_straps_i;
      str_s2_q <= str_s1_q;
      en_s1_q  <= eeprom_present_pin_i;
      en_s2_q  <= en_s1_q;
    end

  sel_wire i_sel_wire (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (start_q),
    .op_i    (op_q),
    .addr_i  (addr_q),
    .wdata_i (wd_q),
    .do_i    (eeprom_do_i),
    .ser_o   (eeprom_o),
    .rdata_o (rdata),
    .done_o  (done)
  );

  assign busy = (st_q != S_IDLE);
  assign access_blocked_o = busy;
  // Both request bits read high for the whole operation
  assign control_register_o = busy ?
    '{select: ctl_q.select, reload: 1'b1, store: 1'b1} : ctl_q;

  // Sequencer; waits two cycles after reset so the synchronisers settle
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      st_q    <= S_INIT;
      ctl_q   <= '0;
      step_q  <= 2'h0;
      sa_q    <= 2'h0;
      is_sa_q <= 1'b0;
      wr_op_q <= 1'b0;
      start_q <= 1'b0;
      op_q    <= OP_READ;
      addr_q  <= '0;
      wd_q    <= '0;
      strap_q <= 3'h0;
    end
    else
    begin
      start_q <= 1'b0;
      case (st_q)
        S_INIT:
        begin
          // Straps taken once both stages hold pin levels and two agree
          step_q  <= {step_q[0], 1'b1};
          strap_q <= str_s2_q;
          if (step_q[1] && str_s2_q == strap_q)
          begin
            if (!en_s2_q)
              st_q <= S_IDLE;
            else
            begin
              ctl_q.reload <= 1'b1;
              wr_op_q <= 1'b0;
              is_sa_q <= (str_s2_q == STRAP_DFLT);
              sa_q    <= 2'h0;
              step_q  <= 2'h0;
              st_q    <= S_NEXT;
            end
          end
        end
        S_IDLE:
          if (ctl_wr_i && en_s2_q && (ctl_wdata_i.reload || ctl_wdata_i.store))
          begin
            ctl_q   <= ctl_wdata_i;
            wr_op_q <= ctl_wdata_i.store && !ctl_wdata_i.reload;
            is_sa_q <= 1'b0;
            sa_q    <= 2'h0;
            step_q  <= 2'h0;
            st_q    <= (ctl_wdata_i.store && !ctl_wdata_i.reload) ?
                       S_EWEN : S_NEXT;
            if (ctl_wdata_i.store && !ctl_wdata_i.reload)
            begin
              op_q    <= OP_EWEN;
              addr_q  <= EWEN_ADDR;
              start_q <= 1'b1;
            end
          end
          else if (ctl_wr_i)
            ctl_q.select <= ctl_wdata_i.select;
        S_EWEN:
          if (done)
            st_q <= S_NEXT;
        S_NEXT:
        begin
          op_q    <= wr_op_q ? OP_WRITE : OP_READ;
          start_q <= 1'b1;
          st_q    <= S_XFER;
          if (ctl_q.select)
          begin
            addr_q <= ptr_o;
            wd_q   <= gp_o;
          end
          else if (is_sa_q)
            addr_q <= SA_BASE + {4'h0, sa_q};
          else
          begin
            addr_q <= slot_addr(strap_q, step_q[0]);
            wd_q   <= step_q[0] ? base_o : cfg_o;
          end
        end
        S_XFER:
          if (done)
          begin
            if (ctl_q.select || (wr_op_q && step_q[0])
                || (is_sa_q && sa_q == SA_LAST))
            begin
              ctl_q.reload <= 1'b0;
              ctl_q.store  <= 1'b0;
              st_q         <= S_IDLE;
            end
            else
            begin
              st_q <= S_NEXT;
              if (!is_sa_q && step_q[0])
                is_sa_q <= 1'b1;
              else if (is_sa_q)
                sa_q <= sa_q + 2'h1;
              step_q <= step_q + 2'h1;
            end
          end
        default:
          st_q <= S_IDLE;
      endcase
    end

  // Loaded words; host writes land only when no operation runs
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cfg_o  <= CFG_DFLT;
      base_o <= BASE_DFLT;
      gp_o   <= '0;
      ptr_o  <= '0;
      station_address_word_o <= '0;
    end
    else if (st_q == S_XFER && done && !wr_op_q)
    begin
      if (ctl_q.select)
        gp_o <= rdata;
      else if (is_sa_q)
        station_address_word_o[DW*sa_q +: DW] <= rdata;
      else if (step_q[0])
        base_o <= rdata;
      else
        cfg_o <= rdata;
    end
    else if (!busy)
    begin
      if (cfg_wr_i)
        cfg_o <= wdata_i;
      if (base_wr_i)
        base_o <= wdata_i;
      if (gp_wr_i)
        gp_o <= wdata_i;
      if (ptr_wr_i)
        ptr_o <= wdata_i[AW-1:0];
      for (int i = 0; i < 3; i++)
        if (sa_wr_i[i])
          station_address_word_o[DW*i +: DW] <= wdata_i;
    end
endmodule // sel_loader

// File: testbench/sel_loader_asserts.sv
`timescale 1ns/100ps
module sel_loader_asserts
  import sel_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            eeprom_present_pin_i,
  input  sel_ser_t             eeprom_o,
  input  wire logic            ctl_wr_i,
  input  sel_ctl_t             ctl_wdata_i,
  input  sel_ctl_t             control_register_o,
  input  wire logic            ptr_wr_i,
  input  wire logic [DW-1:0]   cfg_o,
  input  wire logic [DW-1:0]   base_o,
  input  wire logic [DW-1:0]   gp_o,
  input  wire logic [AW-1:0]   ptr_o,
  input  wire logic [3*DW-1:0] station_address_word_o,
  input  wire logic            access_blocked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  busy_bits_a: assert property (
    access_blocked_o |-> control_register_o.reload && control_register_o.store)
    else $error("busy without both bits");
  done_clear_a: assert property (
    $fell(access_blocked_o) |->
      !control_register_o.reload && !control_register_o.store)
    else $error("bits left set at end");
  start_op_a: assert property (
    !access_blocked_o && ctl_wr_i && eeprom_present_pin_i &&
    (ctl_wdata_i.reload || ctl_wdata_i.store) |=>
      control_register_o.reload && control_register_o.store)
    else $error("request not taken");
  cs_quiet_a: assert property (
    !access_blocked_o [*2] |-> !eeprom_o.cs)
    else $error("select while idle");
  no_part_a: assert property (
    !eeprom_present_pin_i [*8] |-> !eeprom_o.cs)
    else $error("access with part absent");
  sel_keep_a: assert property (
    access_blocked_o && control_register_o.select |=> $stable(cfg_o) &&
      $stable(base_o) && $stable(station_address_word_o))
    else $error("setup changed in word mode");
  gp_keep_a: assert property (
    access_blocked_o && !control_register_o.select |=> $stable(gp_o))
    else $error("gp changed in normal mode");
  ptr_lock_a: assert property (
    access_blocked_o && ptr_wr_i |=> $stable(ptr_o))
    else $error("pointer written while busy");
  cover property ($fell(access_blocked_o) && control_register_o.select);
  cover property (ctl_wr_i && ctl_wdata_i.store && !access_blocked_o);
  cover property (!eeprom_present_pin_i && ctl_wr_i);
endmodule // sel_loader_asserts

bind sel_loader sel_loader_asserts i_sel_loader_asserts (.clk_i, .rst_n_i,
  .eeprom_present_pin_i, .eeprom_o, .ctl_wr_i, .ctl_wdata_i,
  .control_register_o, .ptr_wr_i, .cfg_o, .base_o, .gp_o, .ptr_o,
  .station_address_word_o, .access_blocked_o);

// File: testbench/sel_eeprom_model.sv
`timescale 1ns/100ps
module sel_eeprom_model
  import sel_pkg::*;
(
  input  sel_ser_t ser_i,
  output logic     do_o
);
  logic [DW-1:0] mem [64];
  logic [8:0]    cmd;
  logic [DW-1:0] sh;
  logic [DW-1:0] wsh;
  int            cnt = 0;
  logic          wen = 1'b0;
  logic          pend = 1'b0;
  initial
  begin
    do_o = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = {~8'(i), 8'(i)};
  end
  // Leading zeros before the start bit are not counted
  always @(posedge ser_i.sk)
    if (ser_i.cs && (cnt > 0 || ser_i.di))
    begin
      if (cnt < 9) cmd = {cmd[7:0], ser_i.di};
      else wsh = {wsh[14:0], ser_i.di};
      cnt++;
      if (cnt == 9) sh = mem[cmd[5:0]];
    end
  always @(negedge ser_i.sk)
    if (ser_i.cs && cnt >= 9 && cnt < 25 && cmd[7:6] == OP_READ)
    begin
      do_o = sh[15];
      sh = sh << 1;
    end
  always @(negedge ser_i.cs)
  begin
    if (cnt == 9 && cmd[7:6] == OP_EWEN && cmd[5:4] == 2'h3) wen = 1'b1;
    if (cnt == 25 && cmd[7:6] == OP_WRITE && wen)
    begin
      mem[cmd[5:0]] = wsh;
      pend = 1'b1;
    end
    cnt = 0;
    // Released line: show the opposite of the last level, not a held value
    do_o = ~do_o;
  end
  // Ready appears only after select returns and a busy span has passed
  always @(posedge ser_i.cs)
    if (pend)
    begin
      do_o = 1'b0;
      #2000 do_o = 1'b1;
      pend = 1'b0;
    end
endmodule // sel_eeprom_model

// File: testbench/sel_loader_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b, m) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("BAD %0t %s", $time, m); \
    end \
  end
module sel_loader_tb_top import sel_pkg::*;;
  logic            clk_i, rst_n_i, pin, ctl_wr, cfg_wr, base_wr, gp_wr, ptr_wr;
  logic [2:0]      straps, sa_wr;
  sel_ctl_t        ctl_wd, ctl_rd;
  sel_ser_t        ser;
  logic            do_w, blk;
  logic [DW-1:0]   wdata, cfg, base, gp;
  logic [AW-1:0]   ptr;
  logic [3*DW-1:0] sa;
  int              failures = 0;
  int              total_checks = 0;
  sel_loader i_sel_loader (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .board_select_straps_i(straps), .eeprom_present_pin_i(pin),
    .eeprom_do_i(do_w), .eeprom_o(ser), .ctl_wr_i(ctl_wr),
    .ctl_wdata_i(ctl_wd), .control_register_o(ctl_rd), .cfg_wr_i(cfg_wr),
    .base_wr_i(base_wr), .gp_wr_i(gp_wr), .ptr_wr_i(ptr_wr),
    .sa_wr_i(sa_wr), .wdata_i(wdata), .cfg_o(cfg), .base_o(base),
    .gp_o(gp), .ptr_o(ptr), .station_address_word_o(sa),
    .access_blocked_o(blk));
  sel_eeprom_model i_sel_eeprom_model (.ser_i(ser), .do_o(do_w));
  function automatic logic [DW-1:0] m(input int a);
    return i_sel_eeprom_model.mem[a];
  endfunction
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input int k, input logic [DW-1:0] v);
    @(negedge clk_i);
    wdata = v;
    {cfg_wr, base_wr, gp_wr, ptr_wr} = 4'h8 >> k;
    @(negedge clk_i);
    {cfg_wr, base_wr, gp_wr, ptr_wr} = 4'h0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (blk !== 1'b0 && n < 60000)
    begin
      @(negedge clk_i);
      n++;
    end
    `CHK({ctl_rd.reload, ctl_rd.store}, 2'h0, "bits stuck")
  endtask
  task automatic op(input logic s, input logic rl, input logic st);
    @(negedge clk_i);
    ctl_wd = '{s, rl, st};
    ctl_wr = 1'b1;
    @(negedge clk_i);
    ctl_wr = 1'b0;
    `CHK({ctl_rd.reload, ctl_rd.store}, {2{pin}}, "busy bits")
    wait_idle();
  endtask
  task automatic boot(input logic [2:0] s, input logic p);
    rst_n_i = 1'b0;
    straps = s;
    pin = p;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    // Writes while the boot fetch runs must be dropped
    if (p) wr(3, 16'h0015);
    if (p) wr(0, 16'hdead);
    wait_idle();
  endtask
  task automatic s_boot();
    boot(3'h3, 1'b1);
    `CHK(cfg, m(12), "cfg slot")
    `CHK(base, m(13), "base slot")
    `CHK(sa, {m(34), m(33), m(32)}, "station")
    `CHK(ptr, 6'h00, "ptr locked")
  endtask
  task automatic s_store();
    wr(0, 16'hc0de);
    wr(1, 16'h0b5e);
    op(1'b0, 1'b0, 1'b1);
    `CHK(m(12), 16'hc0de, "cfg stored")
    `CHK(m(13), 16'h0b5e, "base stored")
    wr(0, 16'h0000);
    op(1'b0, 1'b1, 1'b0);
    `CHK(cfg, 16'hc0de, "cfg reloaded")
  endtask
  task automatic s_gp();
    wr(3, 16'hffbf);
    wr(2, 16'h1357);
    op(1'b1, 1'b0, 1'b1);
    `CHK(m(63), 16'h1357, "gp stored")
    `CHK(ctl_rd.select, 1'b1, "select kept")
    wr(3, 16'h0005);
    op(1'b1, 1'b1, 1'b0);
    `CHK(gp, m(5), "gp loaded")
    `CHK(cfg, 16'hc0de, "cfg kept")
  endtask
  task automatic s_strap7();
    boot(3'h7, 1'b1);
    `CHK(cfg, CFG_DFLT, "cfg default")
    `CHK(base, BASE_DFLT, "base default")
    `CHK(sa, {m(34), m(33), m(32)}, "station")
  endtask
  task automatic s_nopin();
    boot(3'h5, 1'b0);
    `CHK(base, BASE_DFLT, "base default")
    op(1'b0, 1'b1, 1'b0);
    `CHK(sa, 48'h0, "no fetch")
    @(negedge clk_i);
    wdata = 16'hbeef;
    sa_wr = 3'h2;
    @(negedge clk_i);
    sa_wr = 3'h0;
    `CHK(sa, {16'h0, 16'hbeef, 16'h0}, "host station")
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    {pin, ctl_wr, cfg_wr, base_wr, gp_wr, ptr_wr} = 6'h20;
    straps = 3'h3;
    sa_wr = 3'h0;
    ctl_wd = '0;
    wdata = '0;
    s_boot();
    s_store();
    s_gp();
    s_strap7();
    s_nopin();
    wrap_up();
  end
  // Expected run is near 60000 cycles
  initial
  begin
    #360000;
    failures++;
    wrap_up();
  end
endmodule // sel_loader_tb_top
